// *** afe_ctl_regs.svh ***
/*
  register offsets, field positions, reset values and timing counts for the
  front-end control block. assumes it is included by bare name.
*/
`ifndef AFE_CTL_REGS_SVH
`define AFE_CTL_REGS_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define AFE_OFS_FAULT_STATUS   8'h01
`define AFE_OFS_INPUT_SELECT   8'h02
`define AFE_OFS_AMP_SETTING    8'h03
`define AFE_OFS_EXC_CTRL_ONE   8'h06
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define AFE_POS_SEL_MSB        7
`define AFE_NEG_SEL_MSB        3
`define AFE_GAIN_LSB           0
`define AFE_PWR_LSB            5
`define AFE_RAIL_EN_BIT        7
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define AFE_RST_INPUT_SELECT   8'h01
`define AFE_RST_AMP_SETTING    8'h00
`define AFE_RST_EXC_CTRL_ONE   8'h00
// ----------------------------------------------------------------------
// timing: mid-supply hold of two system clock periods
// ----------------------------------------------------------------------
`define AFE_BREAK_CLK_PERIODS  2
`endif

// *** afe_ctl_pkg.sv ***
/*
  types for the front-end control block.
  assumes the register header is compiled alongside.
*/
package afe_ctl_pkg;
  // mux sequencing states
  typedef enum logic [1:0] {
    AFE_MUX_CONNECTED = 2'b00,
    AFE_MUX_BREAK     = 2'b01
  } afe_mux_state_t;
  // amplifier power coding
  typedef enum logic [1:0] {
    AFE_PWR_BYPASS = 2'b00,
    AFE_PWR_ON     = 2'b01,
    AFE_PWR_RSV2   = 2'b10,
    AFE_PWR_RSV3   = 2'b11
  } afe_pwr_t;
endpackage

// *** afe_sync.sv ***
/*
  two-flop level synchroniser, parameterised width.
  assumes inputs are asynchronous to clock.
*/
`timescale 1ns/10ps
module afe_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  // a zero-width synchroniser has nothing to carry
  if (WIDTH < 1) begin : gWidthCheck
    $error("afe_sync needs a width of at least one");
  end
  logic [WIDTH-1:0] meta_q;   // first stage, read only by second
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;   // second stage
  logic [WIDTH-1:0] sync_d;
  // ----------------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------------
  always_comb begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end
  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign syncOut = sync_q;
endmodule

// *** afe_ctl.sv ***
/*
  front-end control: input mux select with break-before-make, system
  monitor routing, amplifier gain/power coding with digital scaling above
  gain 32, rail flags, conversion start and result-ready signalling.
  assumes a register port from the serial interface on the same clock,
  and rail comparators, start pin and converter system clock from outside it.
*/
// Summary of operation
// (R1) two 4-bit fields pick amplifier inputs
// (R2) shared input selectable on either side
// (R3) select change: mid-supply two clocks first
// (R4) monitor codes: short, temp, supplies, burnout
// (R5) 3-bit gain field, gains 1 to 128
// (R6) power 00 bypass, 01 enable
// (R7) host never writes power codes 10/11
// (R8) gain 64/128 runs analog 32 plus digital
// (R9) four rail flags in status register
// (R10) rail detect only when enable set
// (R11) host bypasses only at gain 1
// (R12) start by pin or command, continuous/single
// (R13) serial out shows ready then data
// (R14) optional crc with conversion data
// (R15) host may tie chip select low
// (R16) system clock internal or external tick; only the external tick is used here
`timescale 1ns/10ps
`include "afe_ctl_regs.svh"
module afe_ctl
  import afe_ctl_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       sysClkTick,      // converter system clock, async level
  input  wire logic       regWrite,        // register write strobe
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  input  wire logic [3:0] railCompare,     // async comparators pH,pL,nH,nL
  input  wire logic       startPin,        // async start/sync pin
  input  wire logic       startCommand,    // command start pulse
  input  wire logic       singleShot,      // 1: single conversion mode
  input  wire logic       crcEnable,
  input  wire logic       resultDone,      // converter finished a result
  input  wire logic       shiftOut,        // next data bit request
  input  wire logic       dataBit,         // data or crc bit to send
  output logic      [3:0] positiveMuxCode, // applied positive select
  output logic      [3:0] negativeMuxCode, // applied negative select
  output logic            midSupplyTie,    // inputs tied to mid-supply
  output logic      [2:0] analogGainCode,  // gain driven into amplifier
  output logic      [1:0] digitalShift,    // extra digital scaling, log2
  output logic            amplifierPowered,
  output logic            amplifierBypass,
  output logic            convertRun,      // conversion in progress
  output logic            appendCrc,
  output logic            serial_out_with_result_ready
);
  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [7:0] inputSel_q, inputSel_d;     // positive/negative select fields
  logic [7:0] ampSet_q, ampSet_d;         // gain and power fields
  logic [7:0] excOne_q, excOne_d;         // rail detect enable
  logic [3:0] railFlag_q, railFlag_d;     // status flags
  logic [7:0] rdata_q, rdata_d;
  afe_mux_state_t muxState_q, muxState_d;
  logic [1:0] breakCnt_q, breakCnt_d;     // system clock periods held
  logic [3:0] posOut_q, posOut_d, negOut_q, negOut_d;
  logic       tie_q, tie_d;
  logic [2:0] gain_q, gain_d;
  logic [1:0] shift_q, shift_d;
  logic       pwr_q, pwr_d, byp_q, byp_d;
  logic       run_q, run_d, crc_q, crc_d;
  logic       dout_q, dout_d;
  logic       startPrev_q, startPrev_d;
  logic [3:0] railSync;
  logic       startSync;
  logic       sysClkSync;                 // synchronised system clock level
  logic       sysClkPrev_q, sysClkPrev_d; // level one clock earlier
  logic       sysClkEdge;                 // one clock per system clock period
  afe_pwr_t   pwrField;
  // ----------------------------------------------------------------------
  // synchronisers for pins
  // ----------------------------------------------------------------------
  afe_sync #(.WIDTH(6)) uSync (
    .clock   (clock),
    .reset_n (reset_n),
    .asyncIn ({sysClkTick, startPin, railCompare}),
    .syncOut ({sysClkSync, startSync, railSync})
  );
  // ----------------------------------------------------------------------
  // system clock edge finder
  // ----------------------------------------------------------------------
  // the converter clock is unrelated to clock, so only its synchronised
  // level is trusted; each rising edge found counts one period
  always_comb begin
    sysClkPrev_d = sysClkSync;
    sysClkEdge   = sysClkSync && !sysClkPrev_q;                     // R16
  end
  // fixed mapping: gain code to analog code, capped at 32 only while the amplifier is on
  function automatic logic [2:0] analogGain(input logic [2:0] g, input logic on);
    analogGain = (on && g > 3'h5) ? 3'h5 : g;
  endfunction
  // ----------------------------------------------------------------------
  // register file next values
  // ----------------------------------------------------------------------
  always_comb begin
    inputSel_d = inputSel_q;
    ampSet_d   = ampSet_q;
    excOne_d   = excOne_q;
    rdata_d    = rdata_q;
    if (regWrite) begin
      case (regAddr)
        `AFE_OFS_INPUT_SELECT: inputSel_d = regWdata;   // R1 R2 R4
        `AFE_OFS_AMP_SETTING:  ampSet_d   = regWdata;   // R5 R6
        `AFE_OFS_EXC_CTRL_ONE: excOne_d   = regWdata;
        default: ;                                      // unmapped or read-only
      endcase
    end
    if (regRead) begin
      case (regAddr)
        `AFE_OFS_FAULT_STATUS: rdata_d = {4'h0, railFlag_q};   // R9
        `AFE_OFS_INPUT_SELECT: rdata_d = inputSel_q;
        `AFE_OFS_AMP_SETTING:  rdata_d = ampSet_q;
        `AFE_OFS_EXC_CTRL_ONE: rdata_d = excOne_q;
        default:               rdata_d = 8'h00;
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // rail flags: live comparator state, cleared while detect is off
  // ----------------------------------------------------------------------
  always_comb begin
    railFlag_d = excOne_q[`AFE_RAIL_EN_BIT] ? railSync : 4'h0;   // R9 R10
  end
  // ----------------------------------------------------------------------
  // break-before-make sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    muxState_d = muxState_q;
    breakCnt_d = breakCnt_q;
    posOut_d   = posOut_q;
    negOut_d   = negOut_q;
    tie_d      = tie_q;
    case (muxState_q)
      AFE_MUX_CONNECTED: begin
        // any field change (a write during a break is taken when the break ends, without restarting it)
        if (inputSel_q != {posOut_q, negOut_q}) begin               // R3
          muxState_d = AFE_MUX_BREAK;
          breakCnt_d = 2'h0;
          tie_d      = 1'b1;
        end
      end
      AFE_MUX_BREAK: begin
        if (sysClkEdge) begin                                       // R16
          if (breakCnt_q == 2'(`AFE_BREAK_CLK_PERIODS - 1)) begin   // R3
            muxState_d = AFE_MUX_CONNECTED;
            posOut_d   = inputSel_q[`AFE_POS_SEL_MSB -: 4];         // R1
            negOut_d   = inputSel_q[`AFE_NEG_SEL_MSB -: 4];         // R1
            tie_d      = 1'b0;
          end else begin
            breakCnt_d = breakCnt_q + 2'h1;
          end
        end
      end
      default: muxState_d = AFE_MUX_CONNECTED;
    endcase
  end
  // ----------------------------------------------------------------------
  // amplifier coding
  // ----------------------------------------------------------------------
  always_comb begin
    pwrField = afe_pwr_t'(ampSet_q[`AFE_PWR_LSB +: 2]);
    // reserved codes are never written; treat them as bypass to be safe
    pwr_d  = (pwrField == AFE_PWR_ON);                              // R6 R7
    byp_d  = !pwr_d;                                                // R6 R11
    gain_d = analogGain(ampSet_q[`AFE_GAIN_LSB +: 3], pwr_d);       // R5 R8
    if (pwr_d && ampSet_q[`AFE_GAIN_LSB +: 3] > 3'h5)
      shift_d = 2'(ampSet_q[`AFE_GAIN_LSB +: 3] - 3'h5);            // R8
    else
      shift_d = 2'h0;
  end
  // ----------------------------------------------------------------------
  // conversion control and ready/data output
  // ----------------------------------------------------------------------
  always_comb begin
    startPrev_d = startSync;
    run_d       = run_q;
    crc_d       = crcEnable;                                        // R14
    dout_d      = dout_q;
    if ((startSync && !startPrev_q) || startCommand)
      run_d = 1'b1;                                                 // R12
    else if (!startSync && !startCommand && !singleShot && startPrev_q)
      run_d = 1'b0;
    if (resultDone) begin
      dout_d = 1'b0;                                                // R13
      if (singleShot)
        run_d = 1'b0;                                               // R12
    end else if (shiftOut) begin
      dout_d = dataBit;                                             // R13 R14
    end
  end
  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      inputSel_q  <= `AFE_RST_INPUT_SELECT;
      ampSet_q    <= `AFE_RST_AMP_SETTING;
      excOne_q    <= `AFE_RST_EXC_CTRL_ONE;
      railFlag_q  <= 4'h0;
      rdata_q     <= 8'h00;
      muxState_q  <= AFE_MUX_CONNECTED;
      breakCnt_q  <= 2'h0;
      posOut_q    <= 4'h0;
      negOut_q    <= 4'h1;
      tie_q       <= 1'b0;
      gain_q      <= 3'h0;
      shift_q     <= 2'h0;
      pwr_q       <= 1'b0;
      byp_q       <= 1'b1;
      run_q       <= 1'b0;
      crc_q       <= 1'b0;
      dout_q      <= 1'b1;
      startPrev_q <= 1'b0;
      sysClkPrev_q <= 1'b0;
    end else begin
      inputSel_q  <= inputSel_d;
      ampSet_q    <= ampSet_d;
      excOne_q    <= excOne_d;
      railFlag_q  <= railFlag_d;
      rdata_q     <= rdata_d;
      muxState_q  <= muxState_d;
      breakCnt_q  <= breakCnt_d;
      posOut_q    <= posOut_d;
      negOut_q    <= negOut_d;
      tie_q       <= tie_d;
      gain_q      <= gain_d;
      shift_q     <= shift_d;
      pwr_q       <= pwr_d;
      byp_q       <= byp_d;
      run_q       <= run_d;
      crc_q       <= crc_d;
      dout_q      <= dout_d;
      startPrev_q <= startPrev_d;
      sysClkPrev_q <= sysClkPrev_d;
    end
  end
  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign regRdata                     = rdata_q;
  assign positiveMuxCode              = posOut_q;
  assign negativeMuxCode              = negOut_q;
  assign midSupplyTie                 = tie_q;
  assign analogGainCode               = gain_q;
  assign digitalShift                 = shift_q;
  assign amplifierPowered             = pwr_q;
  assign amplifierBypass              = byp_q;
  assign convertRun                   = run_q;
  assign appendCrc                    = crc_q;
  assign serial_out_with_result_ready = dout_q;
endmodule

// *** afe_ctl_asserts.sv ***
/*
  port checker for the front-end control block.
  assumes one clock domain with an async active-low reset.
*/
`timescale 1ns/10ps
module afe_ctl_asserts (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic       sysClkTick,
  input wire logic [7:0] regAddr,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic       startCommand,
  input wire logic       resultDone,
  input wire logic       shiftOut,
  input wire logic       dataBit,
  input wire logic [3:0] positiveMuxCode,
  input wire logic [3:0] negativeMuxCode,
  input wire logic       midSupplyTie,
  input wire logic [2:0] analogGainCode,
  input wire logic [1:0] digitalShift,
  input wire logic       amplifierPowered,
  input wire logic       amplifierBypass,
  input wire logic       convertRun,
  input wire logic       serial_out_with_result_ready
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // applied codes may only move at the end of a mid-supply break
  AST_CODES_AFTER_BREAK: assert property (($changed(positiveMuxCode)
    || $changed(negativeMuxCode)) |-> $past(midSupplyTie)) else $error("codes moved unbroken");
  // two sync flops, the edge finder and the state register lie between
  AST_BREAK_ENDS_ON_TICK: assert property ($fell(midSupplyTie)
    |-> ($past(sysClkTick, 3) && !$past(sysClkTick, 4))) else $error("break ended off tick");
  AST_BREAK_BOUNDED: assert property ($rose(midSupplyTie) |-> ##[1:80] !midSupplyTie)
    else $error("break too long");
  AST_GAIN_CAP: assert property (amplifierPowered |-> analogGainCode <= 3'h5)
    else $error("analog gain above 32");
  AST_SHIFT_BYPASS: assert property (!amplifierPowered |-> digitalShift == 2'h0)
    else $error("scaling while bypassed");
  AST_BYPASS_PAIR: assert property (amplifierBypass == !amplifierPowered)
    else $error("bypass and power disagree");
  AST_START_CMD: assert property (startCommand |=> convertRun)
    else $error("command did not start");
  AST_READY_LOW: assert property (resultDone && !shiftOut |=>
    !serial_out_with_result_ready) else $error("ready not signalled");
  AST_DATA_OUT: assert property (shiftOut && !resultDone |=>
    serial_out_with_result_ready == $past(dataBit)) else $error("wrong data bit");
  AST_UNMAPPED_READ: assert property (regRead && regAddr == 8'h00 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind afe_ctl afe_ctl_asserts CHK (.clock(clock), .reset_n(reset_n), .sysClkTick(sysClkTick),
  .regAddr(regAddr), .regRead(regRead), .regRdata(regRdata), .startCommand(startCommand),
  .resultDone(resultDone), .shiftOut(shiftOut), .dataBit(dataBit),
  .positiveMuxCode(positiveMuxCode), .negativeMuxCode(negativeMuxCode),
  .midSupplyTie(midSupplyTie), .analogGainCode(analogGainCode), .digitalShift(digitalShift),
  .amplifierPowered(amplifierPowered), .amplifierBypass(amplifierBypass),
  .convertRun(convertRun), .serial_out_with_result_ready(serial_out_with_result_ready));

// *** afe_host_model.sv ***
/*
  host side model: issues register writes and reads.
  assumes the caller is on the falling edge of clock.
*/
`timescale 1ns/10ps
module afe_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] regRdata,
  output logic            regWrite,
  output logic            regRead,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWdata
);
  // no chip-select here: the port stands selected for the whole run
  // idle bus: strobes low, address parked on an unused value
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'hFF;
    regWdata = 8'h00;
  end
  // one-cycle write; power codes 10/11 are never issued here
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge clock);
    regWrite = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
  endtask
  // read data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clock);
    regRead = 1'b0;
    regAddr = ~a;
    d = regRdata;
  endtask
endmodule

// *** tb_top.sv ***
/*
  self-checking bench for the front-end control block.
  assumes the host model drives the register port.
*/
`timescale 1ns/10ps
module tb_top;
  logic       clock, reset_n, sysClkTick, regWrite, regRead, startPin, startCommand;
  logic       singleShot, crcEnable, resultDone, shiftOut, dataBit, midSupplyTie;
  logic       amplifierPowered, amplifierBypass, convertRun, appendCrc, serOut;
  logic [7:0] regAddr, regWdata, regRdata, rv;
  logic [3:0] railCompare, posCode, negCode;
  logic [2:0] analogGainCode;
  logic [1:0] digitalShift;
  int         num_errors = 0;
  int         n_checks = 0;
  // ----------------------------------------------------------------
  // instances and stimulus sources
  // ----------------------------------------------------------------
  afe_host_model HOST (.clock(clock), .regRdata(regRdata), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata));
  afe_ctl DUT (.clock(clock), .reset_n(reset_n), .sysClkTick(sysClkTick),
    .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .regRead(regRead),
    .regRdata(regRdata), .railCompare(railCompare), .startPin(startPin),
    .startCommand(startCommand), .singleShot(singleShot), .crcEnable(crcEnable),
    .resultDone(resultDone), .shiftOut(shiftOut), .dataBit(dataBit),
    .positiveMuxCode(posCode), .negativeMuxCode(negCode), .midSupplyTie(midSupplyTie),
    .analogGainCode(analogGainCode), .digitalShift(digitalShift),
    .amplifierPowered(amplifierPowered), .amplifierBypass(amplifierBypass),
    .convertRun(convertRun), .appendCrc(appendCrc), .serial_out_with_result_ready(serOut));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // free-running converter clock, 125 ns period, offset off both edges
  initial begin
    sysClkTick = 1'b0;
    #2;
    forever #62.5 sysClkTick = ~sysClkTick;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // select change goes through mid-supply before the new pair lands
  task automatic t_mux;
    HOST.wr(8'h02, 8'hC5);
    repeat (2) @(negedge clock);
    chk(8'(midSupplyTie), 8'h01);
    chk(8'({posCode, negCode}), 8'h01);
    for (int i = 0; i < 60 && midSupplyTie; i++) @(negedge clock);
    chk(8'({posCode, negCode}), 8'hC5);
    HOST.rd(8'h02, rv);
    chk(rv, 8'hC5);
  endtask
  // every gain code with the amplifier on, then bypass at gain 1
  task automatic t_amp;
    for (int g = 0; g < 8; g++) begin
      HOST.wr(8'h03, 8'h20 | 8'(g));
      repeat (2) @(negedge clock);
      chk(8'(analogGainCode), (g > 5) ? 8'h05 : 8'(g));
      chk(8'(digitalShift), (g > 5) ? 8'(g - 5) : 8'h00);
      chk(8'({amplifierPowered, amplifierBypass}), 8'h02);
    end
    HOST.wr(8'h03, 8'h00);
    repeat (2) @(negedge clock);
    chk(8'({amplifierPowered, amplifierBypass, digitalShift}), 8'h04);
  endtask
  // rail flags masked until enabled; status is read-only
  task automatic t_rail;
    railCompare = 4'hA;
    repeat (6) @(negedge clock);
    HOST.rd(8'h01, rv);
    chk(rv, 8'h00);
    HOST.wr(8'h06, 8'h80);
    repeat (6) @(negedge clock);
    HOST.wr(8'h01, 8'h05);
    HOST.rd(8'h01, rv);
    chk(rv, 8'h0A);
    HOST.rd(8'h00, rv);
    chk(rv, 8'h00);
  endtask
  // command and pin starts, ready low, data bits, crc flag
  task automatic t_conv;
    singleShot = 1'b1;
    startCommand = 1'b1;
    @(negedge clock);
    startCommand = 1'b0;
    chk(8'(convertRun), 8'h01);
    resultDone = 1'b1;
    @(negedge clock);
    resultDone = 1'b0;
    chk(8'({convertRun, serOut}), 8'h00);
    for (int b = 0; b < 2; b++) begin
      shiftOut = 1'b1;
      dataBit = ~b[0];
      @(negedge clock);
      shiftOut = 1'b0;
      chk(8'(serOut), {7'h00, ~b[0]});
    end
    crcEnable = 1'b1;
    singleShot = 1'b0;
    startPin = 1'b1;
    repeat (5) @(negedge clock);
    chk(8'({appendCrc, convertRun}), 8'h03);
    startPin = 1'b0;
    repeat (5) @(negedge clock);
    chk(8'(convertRun), 8'h00);
  endtask
  initial begin
    reset_n = 1'b0;
    {railCompare, startPin, startCommand, singleShot} = '0;
    {crcEnable, resultDone, shiftOut, dataBit} = '0;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    HOST.rd(8'h03, rv);
    chk(rv, 8'h00);
    chk(8'({posCode, negCode}), 8'h01);
    t_mux();
    t_amp();
    t_rail();
    t_conv();
    end_of_test();
  end
  // watchdog well past the hundred or so cycles the scenarios need
  initial begin
    #100000;
    num_errors++;
    end_of_test();
  end
endmodule
